//--- core/fcs_sequencer.sv
`timescale 1ns/1ns
module fcs_sequencer
  import fcs_pkg::*;
#(
  parameter int unsigned POR_LONG_CYC  = POR_LONG_MS * 1000000 / CLK_NS,   // power-on cycles, select low
  parameter int unsigned POR_SHORT_CYC = POR_SHORT_MS * 1000000 / CLK_NS   // power-on cycles, select high
) (
  input  wire logic              core_clk,            // core clock, 100 MHz
  input  wire logic              rst,                 // async reset, active high
  input  wire logic              cfg_request_n,       // configuration request pin, high level starts, low forces reset
  input  wire logic              cfg_status_n_in,     // status line level
  output logic                   cfg_status_n_out,    // status drive value, always low
  output logic                   cfg_status_n_oe,     // drives status low while high
  input  wire logic              cfg_done_in,         // done line level
  output logic                   cfg_done_out,        // done drive value, always low
  output logic                   cfg_done_oe,         // drives done low while high
  input  wire logic              cfg_byte_clock,      // configuration byte clock pin
  input  wire logic [7:0]        cfg_data,            // configuration data pins
  input  wire logic              user_startup_clock,  // optional start-up clock pin
  input  wire logic              por_delay_select,    // power-on delay strap
  input  wire logic              weak_pullup_disable, // pull-up control pin
  output logic                   user_io_oe,          // user I/O may drive
  output logic                   weak_pullup_en,      // weak pull-ups on
  output logic                   user_mode,           // device in user mode
  output logic                   local_decompress_en, // own decompression and security
  input  wire logic [ADDR_W-1:0] avs_address,         // byte address
  input  wire logic              avs_read,            // read request
  input  wire logic              avs_write,           // write request
  input  wire logic [31:0]       avs_writedata,       // write data
  output logic      [31:0]       avs_readdata,        // read data
  output logic                   avs_waitrequest      // slave not ready
);
  // all sequencer state
  typedef struct packed {
    fcs_state_t       st;          // sequencer state
    logic [TMR_W-1:0] tmr;         // delay timer
    logic [3:0]       osc_div;     // oscillator divider
    logic [CNT_W-1:0] byte_cnt;    // bytes taken
    logic [CNT_W-1:0] byte_total;  // bytes in a full image
    logic [7:0]       last_byte;   // most recent byte
    logic             use_user_clk;
    logic             auto_restart;
    logic             err_sticky;
    logic             por_sel;     // captured delay strap
    logic             cfg_byte_clock_prev;   // byte clock, one cycle older
    logic             uclk_prev;   // user clock, one cycle older
    logic             status_oe;
    logic             done_oe;
    logic             io_oe;
    logic             pullup_en;
    logic             umode;
    logic             decomp_en;
    logic             waitreq;
    logic [31:0]      rdata;
  } fcs_regs_t;

  fcs_regs_t q, d;                 // registered state and its next value

  logic [7:0]       data_s;        // synchronised data
  logic             req_s;         // synchronised request
  logic             status_s;      // synchronised status line
  logic             done_s;        // synchronised done line
  logic             cfg_byte_clock_s;        // synchronised byte clock
  logic             uclk_s;        // synchronised user clock
  logic             por_delay_select_s;      // synchronised strap
  logic             pud_s;         // synchronised pull-up control
  logic             cfg_byte_clock_rise;     // byte clock rising edge
  logic             uclk_rise;     // user clock rising edge
  logic             osc_tick;      // one pulse per oscillator cycle
  logic             init_step;     // one initialization clock cycle
  logic             init_clear;    // hold the init counter at zero
  logic             init_reached;  // initialization cycles done
  logic [CNT_W-1:0] init_limit;    // cycles the chosen clock needs
  logic [CNT_W-1:0] init_count;    // init cycles so far
  logic             sw_error;      // software flags a configuration error
  logic             err_clear;     // software clears the error flag
  logic             por_done;      // power-on delay elapsed

  // all configuration pins pass two flops first; reset and the register bus are used directly
  fcs_sync #(.W(15)) u_sync (
    .core_clk (core_clk),
    .rst      (rst),
    .d        ({cfg_data, cfg_request_n, cfg_status_n_in, cfg_done_in, cfg_byte_clock,
                user_startup_clock, por_delay_select, weak_pullup_disable}),
    .q        ({data_s, req_s, status_s, done_s, cfg_byte_clock_s, uclk_s, por_delay_select_s, pud_s})
  );

  // edges of the sampled clocks; the user clock is resolved only up to half the core rate
  assign cfg_byte_clock_rise = cfg_byte_clock_s && !q.cfg_byte_clock_prev;
  assign uclk_rise = uclk_s && !q.uclk_prev;
  assign osc_tick  = (q.osc_div == 4'(OSC_DIV_CYC - 1));

  // init clock: user clock only after the done-to-user-clock delay, else the oscillator
  assign init_clear = (q.st != ST_INIT);
  assign init_step  = q.use_user_clk ? (uclk_rise && q.tmr >= TMR_W'(CD2CU_CYC))
                                     : osc_tick;
  assign init_limit = q.use_user_clk ? CNT_W'(INIT_USER_CYCLES) : CNT_W'(INIT_OSC_CYCLES);

  // counts initialization cycles, saturating
  fcs_sat_counter #(.W(CNT_W)) u_init_cnt (
    .core_clk (core_clk),
    .rst      (rst),
    .clear    (init_clear),
    .step     (init_step),
    .limit    (init_limit),
    .count    (init_count),
    .reached  (init_reached)
  );

  // power-on delay picked by the captured strap
  assign por_done = q.por_sel ? (q.tmr >= TMR_W'(POR_SHORT_CYC - 1))
                              : (q.tmr >= TMR_W'(POR_LONG_CYC - 1));

  // bus side decode of one-shot commands, taken at the accepting edge
  assign sw_error  = avs_write && !q.waitreq && avs_address == REG_CTRL && avs_writedata[CTRL_ERROR_BIT];
  assign err_clear = avs_write && !q.waitreq && avs_address == REG_STATE && avs_writedata[STATE_ERR_BIT];

  // next-state logic
  always_comb begin
    d           = q;
    d.cfg_byte_clock_prev = cfg_byte_clock_s;
    d.uclk_prev = uclk_s;
    d.osc_div   = osc_tick ? 4'h0 : q.osc_div + 4'h1;
    d.tmr       = (q.tmr == '1) ? q.tmr : q.tmr + TMR_W'(1);
    // sequencer
    case (q.st)
      ST_POR: begin
        // strap caught once it is past its synchroniser
        if (q.tmr == TMR_W'(SYNC_DELAY_CYC)) begin
          d.por_sel = por_delay_select_s;
        end
        if (por_done && q.tmr > TMR_W'(SYNC_DELAY_CYC)) begin
          d.st = ST_RESET;
        end
      end
      ST_RESET: begin
        // the source's enable low during its power-on holds us here
        if (req_s && status_s) begin
          d.st       = ST_CONFIG;
          d.byte_cnt = '0;
        end
      end
      ST_CONFIG: begin
        if (!status_s || sw_error) begin
          d.st = ST_ERROR;
        end else if (cfg_byte_clock_rise) begin
          d.byte_cnt  = q.byte_cnt + CNT_W'(1);
          d.last_byte = data_s;
          if (q.byte_cnt + CNT_W'(1) == q.byte_total) begin
            d.st = ST_DONE_WAIT;
          end
        end
      end
      ST_DONE_WAIT: begin
        // the line's rise, not our release, starts initialization
        if (!status_s) begin
          d.st = ST_ERROR;
        end else if (done_s) begin
          d.st = ST_INIT;
        end
      end
      ST_INIT: begin
        if (init_reached) begin
          d.st = ST_USER;
        end
      end
      ST_USER: begin
        d.st = ST_USER;
      end
      ST_ERROR: begin
        if (q.auto_restart && q.tmr >= TMR_W'(RESTART_CYC - 1)) begin
          d.st = ST_RESET;
        end
      end
      default: begin
        d.st = ST_POR;
      end
    endcase
    // request low forces reset from any stage after power-on
    if (q.st != ST_POR && !req_s) begin
      d.st = ST_RESET;
    end
    // timer restarts on every state change
    if (d.st != q.st) begin
      d.tmr = '0;
    end
    // sticky error, the set wins over a clear
    if (d.st == ST_ERROR && q.st != ST_ERROR) begin
      d.err_sticky = 1'b1;
    end else if (err_clear) begin
      d.err_sticky = 1'b0;
    end
    // pin controls follow the next state so they never lag it
    d.status_oe = (d.st == ST_POR) || (d.st == ST_ERROR)
               || (d.st == ST_RESET && !req_s);
    d.done_oe   = !(d.st == ST_DONE_WAIT || d.st == ST_INIT || d.st == ST_USER);
    d.io_oe     = (d.st == ST_USER);
    d.pullup_en = !pud_s && d.st != ST_POR && d.st != ST_USER;
    d.umode     = (d.st == ST_USER);
    d.decomp_en = 1'b0;
    // register bus: one wait cycle, then the access completes
    if ((avs_read || avs_write) && q.waitreq) begin
      d.waitreq = 1'b0;
      case (avs_address)
        REG_CTRL:       d.rdata = {30'h0, q.auto_restart, q.use_user_clk};
        REG_BYTE_TOTAL: d.rdata = {8'h00, q.byte_total};
        REG_STATE:      d.rdata = {26'h0, q.err_sticky, q.umode, !q.done_oe, q.st};
        REG_BYTE_COUNT: d.rdata = {8'h00, q.byte_cnt};
        REG_LAST_BYTE:  d.rdata = {24'h0, q.last_byte};
        default:        d.rdata = 32'h0;
      endcase
    end else begin
      d.waitreq = 1'b1;
    end
    // writes land at the edge where waitrequest is seen low
    if (avs_write && !q.waitreq) begin
      case (avs_address)
        REG_CTRL: begin
          d.use_user_clk = avs_writedata[CTRL_USER_CLK_BIT];
          d.auto_restart = avs_writedata[CTRL_AUTO_RST_BIT];
        end
        REG_BYTE_TOTAL: d.byte_total = avs_writedata[CNT_W-1:0];
        default: ;
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      q            <= '0;
      q.st         <= ST_POR;
      q.byte_total <= BYTE_TOTAL_RST;
      q.status_oe  <= 1'b1;
      q.done_oe    <= 1'b1;
      q.waitreq    <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // outputs straight from flops, the two drive values tied low
  assign cfg_status_n_out    = 1'b0;
  assign cfg_done_out        = 1'b0;
  assign cfg_status_n_oe     = q.status_oe;
  assign cfg_done_oe         = q.done_oe;
  assign user_io_oe          = q.io_oe;
  assign weak_pullup_en      = q.pullup_en;
  assign user_mode           = q.umode;
  assign local_decompress_en = q.decomp_en;
  assign avs_readdata        = q.rdata;
  assign avs_waitrequest     = q.waitreq;

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);

  sequence s_bus_req;
    (avs_read || avs_write) && avs_waitrequest;
  endsequence
  sequence s_error_entry;
    q.st == ST_ERROR && $past(q.st) != ST_ERROR;
  endsequence

  a_por_holds_pins: assert property (q.st == ST_POR |-> q.status_oe && !q.io_oe)
    else $error("power-on state without status low or with I/O driven");
  a_por_long_delay: assert property ((q.st == ST_POR && !q.por_sel && q.tmr > 3
                                      && q.tmr < POR_LONG_CYC - 1) |=> q.st == ST_POR)
    else $error("long power-on delay ended early");
  a_req_low_resets: assert property ((!req_s && q.st != ST_POR) |=> q.st == ST_RESET
                                     && q.status_oe && q.done_oe && !q.io_oe)
    else $error("request low did not force reset");
  a_reset_release: assert property ((q.st == ST_RESET && req_s) ##1 req_s |-> !q.status_oe)
    else $error("status held low with request high");
  a_byte_taken: assert property ((q.st == ST_CONFIG && cfg_byte_clock_rise && status_s && !sw_error && req_s)
                                 |=> q.byte_cnt == $past(q.byte_cnt) + 1 && q.last_byte == $past(data_s))
    else $error("byte clock edge did not capture a byte");
  a_done_released: assert property ($rose(!q.done_oe) |-> q.st == ST_DONE_WAIT
                                    && q.byte_cnt == q.byte_total)
    else $error("done released before all bytes");
  a_pullup_policy: assert property (q.pullup_en |-> q.st != ST_POR && q.st != ST_USER
                                    && !$past(pud_s))
    else $error("weak pull-ups on when they must be off");
  a_user_after_count: assert property ($rose(q.umode) |-> $past(init_reached)
                                       && $past(init_count) == $past(init_limit))
    else $error("user mode entered before init cycles complete");
  a_restart_bound: assert property (q.st == ST_ERROR && q.auto_restart |-> q.tmr < RESTART_CYC)
    else $error("auto restart later than allowed");
  a_error_holds: assert property (s_error_entry |-> q.status_oe && q.err_sticky)
    else $error("error without status low");
  a_no_local_decomp: assert property (!local_decompress_en)
    else $error("own decompression active");
  a_bus_answer: assert property (s_bus_req |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("bus access not answered in one cycle");
endmodule : fcs_sequencer

//--- core/fcs_pkg.sv
package fcs_pkg;
  // core clock and time bases
  localparam int CLK_NS             = 10;        // core_clk period in ns
  localparam int CORE_KHZ           = 100000;    // core_clk rate
  localparam int OSC_KHZ            = 10000;     // internal start-up oscillator rate
  localparam int OSC_DIV_CYC        = CORE_KHZ / OSC_KHZ;
  localparam int POR_LONG_MS        = 100;       // power-on delay, select low
  localparam int POR_SHORT_MS       = 12;        // power-on delay, select high
  localparam int RESTART_US         = 40;        // longest error hold before auto restart
  localparam int RESTART_CYC        = RESTART_US * 1000 / CLK_NS;
  localparam int CFG_BYTE_CLOCK_MAX_PERIOD_NS = 10;        // slowest byte clock period allowed
  localparam int CD2CU_NS           = 4 * CFG_BYTE_CLOCK_MAX_PERIOD_NS;  // done high to user clock enabled
  localparam int CD2CU_CYC          = (CD2CU_NS + CLK_NS - 1) / CLK_NS;
  localparam int INIT_USER_CYCLES   = 299;       // user start-up clock cycles to user mode
  localparam int INIT_OSC_CYCLES    = 299;       // oscillator cycles spent on initialization
  localparam int SYNC_DELAY_CYC     = 2;         // cycles until a strap is past its synchroniser
  // widths
  localparam int TMR_W  = 24;
  localparam int CNT_W  = 24;
  localparam int ADDR_W = 5;
  // register byte offsets
  localparam logic [ADDR_W-1:0] REG_CTRL       = 5'h00;
  localparam logic [ADDR_W-1:0] REG_BYTE_TOTAL = 5'h04;
  localparam logic [ADDR_W-1:0] REG_STATE      = 5'h08;
  localparam logic [ADDR_W-1:0] REG_BYTE_COUNT = 5'h0C;
  localparam logic [ADDR_W-1:0] REG_LAST_BYTE  = 5'h10;
  // field positions
  localparam int CTRL_USER_CLK_BIT  = 0;
  localparam int CTRL_AUTO_RST_BIT  = 1;
  localparam int CTRL_ERROR_BIT     = 2;
  localparam int STATE_DONE_BIT     = 3;
  localparam int STATE_USER_BIT     = 4;
  localparam int STATE_ERR_BIT      = 5;
  // values after reset
  localparam logic [CNT_W-1:0] BYTE_TOTAL_RST = 24'h000100;
  // sequencer states
  typedef enum logic [2:0] {
    ST_POR, ST_RESET, ST_CONFIG, ST_DONE_WAIT, ST_INIT, ST_USER, ST_ERROR
  } fcs_state_t;
endpackage : fcs_pkg

//--- core/fcs_sync.sv
`timescale 1ns/1ns
module fcs_sync #(
  parameter int W = 1                          // number of bits
) (
  input  wire logic         core_clk,          // core clock
  input  wire logic         rst,               // async reset, active high
  input  wire logic [W-1:0] d,                 // asynchronous inputs
  output logic      [W-1:0] q                  // synchronised outputs
);
  // one two-flop chain per bit; the first flop feeds only the second
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_q;                              // first stage
    always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
        meta_q <= 1'b0;
        q[i]   <= 1'b0;
      end else begin
        meta_q <= d[i];
        q[i]   <= meta_q;
      end
    end
  end
endmodule : fcs_sync

//--- core/fcs_sat_counter.sv
`timescale 1ns/1ns
module fcs_sat_counter #(
  parameter int W = 16                         // counter width
) (
  input  wire logic         core_clk,          // core clock
  input  wire logic         rst,               // async reset, active high
  input  wire logic         clear,             // restart from zero
  input  wire logic         step,              // count one cycle
  input  wire logic [W-1:0] limit,             // count that ends the run
  output logic      [W-1:0] count,             // current count
  output logic              reached            // count has reached limit
);
  // saturates at the limit so a late step cannot wrap it
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      count <= '0;
    end else if (clear) begin
      count <= '0;
    end else if (step && count < limit) begin
      count <= count + W'(1);
    end
  end
  assign reached = (count >= limit);
endmodule : fcs_sat_counter

//--- sim/fcs_source_model.sv
`timescale 1ns/1ns
module fcs_source_model #(
  parameter int         POR_NS = 3000,    // own power-on delay in ns
  parameter int         NBYTES = 4,       // bytes in one image
  parameter logic [7:0] BASE   = 8'hC0    // value of the first byte
) (
  input  wire logic       go,             // bench lets a frame start
  input  wire logic       status_line,    // shared status and enable level
  input  wire logic       chip_sel_n,     // done line, active-low select
  output logic            enable_low,     // pulls the status line low while high
  output logic            byte_clock,     // byte clock, still outside frames
  output logic [7:0]      data            // configuration byte
);
  // hold the shared line low through own power-on, then let go
  initial begin
    enable_low = 1'b1;
    byte_clock = 1'b0;
    data       = 8'h5A;
    #POR_NS enable_low = 1'b0;
  end
  // one byte per byte-clock cycle once status is high and we are selected
  always begin
    wait (go && status_line === 1'b1 && chip_sel_n === 1'b0 && !enable_low);
    for (int i = 0; i < NBYTES; i++) begin
      data = BASE + 8'(i);
      #62 byte_clock = 1'b1;
      #63 byte_clock = 1'b0;
    end
    data = ~data; // released lines show no stale byte
    wait (chip_sel_n === 1'b1 || !go);
    wait (!go);
  end
endmodule : fcs_source_model

//--- sim/fcs_sequencer_bench.sv
`timescale 1ns/1ns
module fcs_sequencer_bench;
  import fcs_pkg::*;
  logic              core_clk, rst, cfg_request_n, por_delay_select, weak_pullup_disable;
  logic              status_oe, done_oe, user_io_oe, weak_pullup_en, user_mode, local_decompress_en;
  logic              user_startup_clock, uclk_run, go, src_low, byte_clock;
  logic [7:0]        data;
  logic [ADDR_W-1:0] avs_address;
  logic              avs_read, avs_write, avs_waitrequest;
  logic [31:0]       avs_writedata, avs_readdata, q;
  wire               status_line = !(status_oe || src_low); // pulled-up open drain
  wire               done_line = !done_oe;                   // pulled-up open drain
  int                err_count, tests_run, n;
  fcs_sequencer #(.POR_LONG_CYC(200), .POR_SHORT_CYC(100)) dut (
    .core_clk(core_clk), .rst(rst), .cfg_request_n(cfg_request_n), .cfg_status_n_in(status_line),
    .cfg_status_n_out(), .cfg_status_n_oe(status_oe), .cfg_done_in(done_line), .cfg_done_out(),
    .cfg_done_oe(done_oe), .cfg_byte_clock(byte_clock), .cfg_data(data),
    .user_startup_clock(user_startup_clock), .por_delay_select(por_delay_select),
    .weak_pullup_disable(weak_pullup_disable), .user_io_oe(user_io_oe), .weak_pullup_en(weak_pullup_en),
    .user_mode(user_mode), .local_decompress_en(local_decompress_en), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  fcs_source_model src (.go(go), .status_line(status_line), .chip_sel_n(done_line),
    .enable_low(src_low), .byte_clock(byte_clock), .data(data));
  // core clock and user start-up clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  always #40 if (uclk_run) user_startup_clock = ~user_startup_clock;
  // compare and count
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  // one register access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge core_clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    // look half a cycle ahead so the value seen is the one standing at the next rising edge
    do begin
      @(negedge core_clk);
      k++;
    end while (avs_waitrequest !== 1'b0 && k < 50);
    @(posedge core_clk);
    q = avs_readdata;
    if (k >= 50) err_count++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask : bus
  // wait a bounded number of cycles for a level
  task automatic wait_lvl(ref logic s, input logic v, input int lim);
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge core_clk);
      n++;
    end
  endtask : wait_lvl
  // reset, then time the power-on hold of the status line
  task automatic por_run(input logic sel, input int exp);
    rst <= 1'b1;
    por_delay_select <= sel;
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("status held", 32'h1, 32'(status_oe));
    chk("io tristate", 32'h0, 32'(user_io_oe));
    wait_lvl(status_oe, 1'b0, exp + 50);
    chk("por length", 32'h1, 32'(n + 6 >= exp && n <= exp + 10));
  endtask : por_run
  // verdict
  task automatic test_done();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : test_done
  initial begin
    #500000;
    err_count++;
    test_done();
  end
  // main sequence
  initial begin
    {rst, cfg_request_n, por_delay_select, weak_pullup_disable} = 4'hC;
    {user_startup_clock, uclk_run, go, avs_read, avs_write} = 5'h0;
    avs_address = 5'h00;
    avs_writedata = 32'h0;
    err_count = 0;
    tests_run = 0;
    por_run(1'b0, 200);
    por_run(1'b1, 100);
    chk("pullup on", 32'h1, 32'(weak_pullup_en));
    weak_pullup_disable <= 1'b1;
    repeat (4) @(posedge core_clk);
    chk("pullup off", 32'h0, 32'(weak_pullup_en));
    weak_pullup_disable <= 1'b0;
    chk("own decompression", 32'h0, 32'(local_decompress_en));
    $display("test power-on done");
    bus(1'b0, REG_BYTE_TOTAL, 32'h0);
    chk("byte total reset", 32'h100, q);
    bus(1'b1, REG_BYTE_TOTAL, 32'h4);
    bus(1'b0, REG_BYTE_TOTAL, 32'h0);
    chk("byte total", 32'h4, q);
    bus(1'b0, 5'h14, 32'h0);
    chk("unmapped read", 32'h0, q);
    $display("test registers done");
    go <= 1'b1;
    wait_lvl(done_oe, 1'b0, 4000);
    chk("done released", 32'h1, 32'(n < 4000));
    wait_lvl(user_mode, 1'b1, 4000);
    chk("osc init", 32'h1, 32'(n + 5 >= 299 * OSC_DIV_CYC && n <= 299 * OSC_DIV_CYC + 40));
    chk("io on", 32'h1, 32'(user_io_oe && !weak_pullup_en));
    bus(1'b0, REG_BYTE_COUNT, 32'h0);
    chk("byte count", 32'h4, q);
    bus(1'b0, REG_LAST_BYTE, 32'h0);
    chk("last byte", 32'hC3, q);
    $display("test first load done");
    go <= 1'b0;
    cfg_request_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk("restart pulls", 32'h3, 32'({status_oe, done_oe} & {1'b1, !user_io_oe}));
    bus(1'b1, REG_CTRL, 32'h1);
    repeat (50) @(posedge core_clk);
    chk("held in reset", 32'h1, 32'(status_oe));
    cfg_request_n <= 1'b1;
    wait_lvl(status_oe, 1'b0, 50);
    chk("status release", 32'h1, 32'(n < 50));
    go <= 1'b1;
    wait_lvl(done_oe, 1'b0, 4000);
    repeat (500) @(posedge core_clk);
    chk("waits user clock", 32'h0, 32'(user_mode));
    uclk_run <= 1'b1;
    repeat (290 * 8) @(posedge core_clk);
    chk("user count early", 32'h0, 32'(user_mode));
    wait_lvl(user_mode, 1'b1, 300);
    chk("user count", 32'h1, 32'(n < 300));
    $display("test user clock load done");
    go <= 1'b0;
    cfg_request_n <= 1'b0;
    repeat (4) @(posedge core_clk);
    cfg_request_n <= 1'b1;
    wait_lvl(status_oe, 1'b0, 50);
    repeat (6) @(posedge core_clk);
    bus(1'b1, REG_CTRL, 32'h6);
    wait_lvl(status_oe, 1'b1, 10);
    chk("error pulls", 32'h1, 32'(n < 10));
    wait_lvl(status_oe, 1'b0, RESTART_CYC + 50);
    chk("auto restart", 32'h1, 32'(n <= RESTART_CYC + 5));
    bus(1'b0, REG_STATE, 32'h0);
    chk("error flag", 32'h1, 32'(q[STATE_ERR_BIT]));
    $display("test error done");
    test_done();
  end
endmodule : fcs_sequencer_bench
